// ==== eds_top.sv ====
// Purpose: Encoder feedback supervisor with speed, divider and faults.
// Assumes: APB master; encoder on enc_a and enc_b.
// Notes:   Speed is refreshed once per tenth of a second.
`timescale 1ns/100ps
module eds_top #(
   parameter int unsigned TENTH_CYC = eds_pkg::TENTH_CYC_DEF // 0.1 s.
) (
   input  wire logic        clk,           // 200 MHz clock.
   input  wire logic        reset,         // Sync reset, high.
   input  wire logic        psel,          // APB select.
   input  wire logic        penable,       // APB enable.
   input  wire logic        pwrite,        // APB write.
   input  wire logic [7:0]  paddr,         // APB byte address.
   input  wire logic [31:0] pwdata,        // APB write data.
   output logic      [31:0] prdata,        // APB read data.
   output logic             pready,        // APB ready.
   output logic             pslverr,       // APB error.
   input  wire logic        enc_a,         // Encoder phase A.
   input  wire logic        enc_b,         // Encoder phase B.
   output logic             pulse_out,     // Divided pulse train.
   output logic             stop_decel,    // Decelerate to stop.
   output logic             stop_coast,    // Coast to stop.
   output logic             irq,           // Interrupt, level.
   output logic             overspeed_fault,       // Fault held.
   output logic             speed_deviation_fault, // Fault held.
   output logic             encoder_open_fault     // Fault held.
);
   import eds_pkg::*;
   typedef enum logic [1:0] {DV_IDLE, DV_RUN, DV_DONE} eds_dv_type;

   eds_enc_if enc ();
   eds_quad u_quad (
      .clk   (clk),
      .reset (reset),
      .enc_a (enc_a),
      .enc_b (enc_b),
      .enc   (enc)
   );

   logic [1:0]  os_act_ff, dev_act_ff, pgo_act_ff;
   logic        pol_ff;
   logic [6:0]  os_lvl_ff, dev_time_ff, pgo_time_ff;
   logic [4:0]  os_time_ff;
   logic [5:0]  dev_lvl_ff;
   logic [15:0] ppr_ff, cmd_ff, max_ff, speed_ff;
   logic [7:0]  div_ff;
   logic [9:0]  g1_ff, g2_ff;
   logic [2:0]  sts_ff, mask_ff;
   logic        rev_ff, irq_ff, pready_ff, pslverr_ff;
   logic [31:0] prdata_ff, rd_data, tick_cnt_ff;
   logic        acc_req, wr_take, wr_ok, rd_ok, frst;
   logic        tick_ff, tick_d_ff, upd_ff, noedge_ff, any_ff, neg_ff;
   logic signed [20:0] win_ff;
   logic [19:0] mag_ff;
   eds_dv_type  dv_ff;
   logic [37:0] quo_ff;
   logic [26:0] rem_ff, trial;
   logic [25:0] den_ff;
   logic [5:0]  bit_ff;
   logic [23:0] spd_pct, cmd_pct, os_lim, dev_lim;
   logic [2:0]  cond, fset_v, coast_v, decel_v;
   logic [6:0]  lim [3];
   logic [1:0]  act [3];
   logic [6:0]  tmr_ff [3];
   logic        fault_ff [3];
   logic        fset_ff [3];
   logic        pulse_ff, decel_ff, coast_ff, div_n;
   logic [5:0]  div_k;
   logic [6:0]  acc_ff, acc_sum;

   assign enc.polarity = pol_ff;
   // =====================================================
   // APB slave: one wait state, answer on the second access cycle.
   assign acc_req = psel & penable & ~pready_ff;
   assign wr_take = psel & penable & pready_ff & pwrite & ~pslverr_ff;
   assign frst    = wr_take & (paddr == ADDR_CTRL) & pwdata[FRST_BIT];

   // Address decode, read mux and range checks on writes.
   always_comb begin
      rd_data = 32'h0;
      rd_ok   = 1'b1;
      wr_ok   = 1'b1;
      case (paddr)
         ADDR_CTRL: begin
            rd_data = {25'h0, pol_ff, pgo_act_ff, dev_act_ff, os_act_ff};
            wr_ok = (pwdata[1:0] != 2'h3) && (pwdata[3:2] != 2'h3) &&
                    (pwdata[5:4] != 2'h3);
         end
         ADDR_OS: begin
            rd_data = {19'h0, os_time_ff, 1'b0, os_lvl_ff};
            wr_ok = (pwdata[6:0] <= OS_LVL_MAX) &&
                    (pwdata[12:8] <= OS_TIME_MAX);
         end
         ADDR_DEV: begin
            rd_data = {17'h0, dev_time_ff, 2'h0, dev_lvl_ff};
            wr_ok = (pwdata[5:0] <= DEV_LVL_MAX) &&
                    (pwdata[14:8] <= DEV_TIME_MAX);
         end
         ADDR_PGO: begin
            rd_data = {25'h0, pgo_time_ff};
            wr_ok = pwdata[6:0] <= PGO_TIME_MAX;
         end
         ADDR_PPR: begin
            rd_data = {16'h0, ppr_ff};
            wr_ok = pwdata[15:0] <= PPR_MAX;
         end
         ADDR_DIV: begin
            rd_data = {24'h0, div_ff};
            wr_ok = (pwdata[7:0] >= 8'h01 && pwdata[7:0] <= 8'h20) ||
                    (pwdata[7:0] >= 8'h65 && pwdata[7:0] <= 8'h84);
         end
         ADDR_GEAR: begin
            rd_data = {6'h0, g2_ff, 6'h0, g1_ff};
            wr_ok = (pwdata[9:0] != 10'h0) && (pwdata[9:0] <= GEAR_MAX) &&
                    (pwdata[25:16] != 10'h0) && (pwdata[25:16] <= GEAR_MAX);
         end
         ADDR_CMD:    rd_data = {16'h0, cmd_ff};
         ADDR_MAX:    rd_data = {16'h0, max_ff};
         ADDR_SPEED: begin
            rd_data = {15'h0, rev_ff, speed_ff};
            wr_ok   = 1'b0;
         end
         ADDR_STATUS: rd_data = {29'h0, sts_ff};
         ADDR_MASK:   rd_data = {29'h0, mask_ff};
         default: begin
            rd_ok = 1'b0;
            wr_ok = 1'b0;
         end
      endcase
   end

   // Answer flops; a refused write leaves every register untouched.
   always_ff @(posedge clk) begin
      if (reset) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0;
      end else begin
         pready_ff  <= acc_req;
         pslverr_ff <= acc_req & ~(pwrite ? wr_ok : rd_ok);
         if (acc_req & ~pwrite)
            prdata_ff <= rd_data;
      end
   end

   // Configuration registers, written at the ready edge.
   always_ff @(posedge clk) begin
      if (reset) begin
         {pol_ff, pgo_act_ff, dev_act_ff, os_act_ff} <= CTRL_RST;
         os_lvl_ff   <= OS_LVL_RST;
         os_time_ff  <= OS_TIME_RST;
         dev_lvl_ff  <= DEV_LVL_RST;
         dev_time_ff <= DEV_TIME_RST;
         pgo_time_ff <= PGO_TIME_RST;
         ppr_ff      <= PPR_RST;
         div_ff      <= DIV_RST;
         g1_ff       <= GEAR_RST;
         g2_ff       <= GEAR_RST;
         cmd_ff      <= 16'h0;
         max_ff      <= MAX_RST;
         mask_ff     <= 3'h0;
      end else if (wr_take) begin
         case (paddr)
            ADDR_CTRL: {pol_ff, pgo_act_ff, dev_act_ff, os_act_ff}
                          <= pwdata[6:0];
            ADDR_OS: begin
               os_lvl_ff  <= pwdata[6:0];
               os_time_ff <= pwdata[12:8];
            end
            ADDR_DEV: begin
               dev_lvl_ff  <= pwdata[5:0];
               dev_time_ff <= pwdata[14:8];
            end
            ADDR_PGO:  pgo_time_ff <= pwdata[6:0];
            ADDR_PPR:  ppr_ff      <= pwdata[15:0];
            ADDR_DIV:  div_ff      <= pwdata[7:0];
            ADDR_GEAR: begin
               g1_ff <= pwdata[9:0];
               g2_ff <= pwdata[25:16];
            end
            ADDR_CMD:  cmd_ff  <= pwdata[15:0];
            ADDR_MAX:  max_ff  <= pwdata[15:0];
            ADDR_MASK: mask_ff <= pwdata[2:0];
            default: ;
         endcase
      end
   end
   // =====================================================
   // Tenth-second tick, the base for speed and all delays.
   always_ff @(posedge clk) begin
      if (reset) begin
         tick_cnt_ff <= 32'h0;
         tick_ff     <= 1'b0;
         tick_d_ff   <= 1'b0;
      end else begin
         tick_ff     <= tick_cnt_ff == TENTH_CYC - 1;
         tick_d_ff   <= tick_ff;
         tick_cnt_ff <= (tick_cnt_ff == TENTH_CYC - 1) ? 32'h0
                                                      : tick_cnt_ff + 32'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         win_ff    <= 21'sh0;
         any_ff    <= 1'b0;
         mag_ff    <= 20'h0;
         neg_ff    <= 1'b0;
         noedge_ff <= 1'b0;
      end else if (tick_ff) begin
         mag_ff    <= win_ff[20] ? 20'(-win_ff) : win_ff[19:0];
         neg_ff    <= win_ff[20];
         noedge_ff <= ~any_ff;
         win_ff    <= enc.step ? (enc.fwd ? 21'sh1 : -21'sh1) : 21'sh0;
         any_ff    <= enc.step;
      end else if (enc.step) begin
         win_ff <= enc.fwd ? win_ff + 21'sh1 : win_ff - 21'sh1;
         any_ff <= 1'b1;
      end
   end
   // =====================================================
   // rpm by serial division
   // Serial division trades 40 cycles of latency for a tiny divider.
   assign trial = {rem_ff[25:0], quo_ff[37]};
   always_ff @(posedge clk) begin
      if (reset) begin
         dv_ff  <= DV_IDLE;
         quo_ff <= 38'h0;
         rem_ff <= 27'h0;
         den_ff <= 26'h0;
         bit_ff <= 6'h0;
      end else begin
         case (dv_ff)
            DV_IDLE: if (tick_d_ff) begin
               quo_ff <= 38'(mag_ff) * 38'(RPM_MUL) * 38'(g2_ff);
               den_ff <= 26'(ppr_ff) * 26'(g1_ff);
               rem_ff <= 27'h0;
               bit_ff <= 6'h0;
               dv_ff  <= DV_RUN;
            end
            DV_RUN: begin
               if (trial >= {1'b0, den_ff}) begin
                  rem_ff <= trial - {1'b0, den_ff};
                  quo_ff <= {quo_ff[36:0], 1'b1};
               end else begin
                  rem_ff <= trial;
                  quo_ff <= {quo_ff[36:0], 1'b0};
               end
               bit_ff <= bit_ff + 6'h1;
               if (bit_ff == DIV_STEPS - 6'h1)
                  dv_ff <= DV_DONE;
            end
            DV_DONE: dv_ff <= DV_IDLE;
            default: dv_ff <= DV_IDLE;
         endcase
      end
   end

   // Speed result; zero resolution reads as standstill.
   always_ff @(posedge clk) begin
      if (reset) begin
         speed_ff <= 16'h0;
         rev_ff   <= 1'b0;
         upd_ff   <= 1'b0;
      end else begin
         upd_ff <= dv_ff == DV_DONE;
         if (dv_ff == DV_DONE) begin
            rev_ff   <= neg_ff;
            speed_ff <= (den_ff == 26'h0) ? 16'h0 :
                        (|quo_ff[37:16]) ? 16'hFFFF : quo_ff[15:0];
         end
      end
   end
   // =====================================================
   // Fault conditions in percent of the full-scale speed.
   always_comb begin
      spd_pct = 24'(speed_ff) * 24'(PCT_FULL);
      cmd_pct = 24'(cmd_ff) * 24'(PCT_FULL);
      os_lim  = 24'(os_lvl_ff) * 24'(max_ff);
      dev_lim = 24'(dev_lvl_ff) * 24'(max_ff);
      cond[0] = spd_pct > os_lim;
      cond[1] = (cmd_pct > spd_pct) && (cmd_pct - spd_pct > dev_lim);
      cond[2] = noedge_ff && (cmd_ff != 16'h0);
      lim[0]  = 7'(os_time_ff);
      lim[1]  = dev_time_ff;
      lim[2]  = pgo_time_ff;
      act[0]  = os_act_ff;
      act[1]  = dev_act_ff;
      act[2]  = pgo_act_ff;
   end

   // One delay timer and held flag per fault.
   for (genvar gi = 0; gi < 3; gi++) begin : g_flt
      always_ff @(posedge clk) begin
         if (reset) begin
            tmr_ff[gi]   <= 7'h0;
            fault_ff[gi] <= 1'b0;
            fset_ff[gi]  <= 1'b0;
         end else begin
            fset_ff[gi] <= 1'b0;
            if (upd_ff && cond[gi] && tmr_ff[gi] >= lim[gi]) begin
               fault_ff[gi] <= 1'b1;
               fset_ff[gi]  <= ~fault_ff[gi];
            end else if (frst) begin
               fault_ff[gi] <= 1'b0;
            end
            if (upd_ff)
               tmr_ff[gi] <= !cond[gi] ? 7'h0 :
                  (tmr_ff[gi] == TMR_SAT) ? TMR_SAT : tmr_ff[gi] + 7'h1;
         end
      end
      assign fset_v[gi]  = fset_ff[gi];
      assign coast_v[gi] = fault_ff[gi] && act[gi] == ACT_COAST;
      assign decel_v[gi] = fault_ff[gi] && act[gi] == ACT_DECEL;
   end

   // stop action
   // Coast wins over decelerate since it is the safer stop.
   always_ff @(posedge clk) begin
      if (reset) begin
         coast_ff <= 1'b0;
         decel_ff <= 1'b0;
      end else begin
         coast_ff <= |coast_v;
         decel_ff <= (|decel_v) & ~(|coast_v);
      end
   end

   // Sticky status: a new fault wins over a write-one clear.
   always_ff @(posedge clk) begin
      if (reset) begin
         sts_ff <= 3'h0;
         irq_ff <= 1'b0;
      end else begin
         sts_ff <= (sts_ff & ~((wr_take && paddr == ADDR_STATUS) ?
                   pwdata[2:0] : 3'h0)) | fset_v;
         irq_ff <= |(sts_ff & mask_ff);
      end
   end
   // =====================================================
   // divided pulse output
   // Each of four edges adds 1+n; toggling at 2k gives (1+n)/k.
   assign div_n   = div_ff >= DIV_HUND;
   assign div_k   = div_n ? 6'(div_ff - DIV_HUND) : div_ff[5:0];
   assign acc_sum = acc_ff + (div_n ? 7'h2 : 7'h1);
   always_ff @(posedge clk) begin
      if (reset) begin
         acc_ff   <= 7'h0;
         pulse_ff <= 1'b0;
      end else if (enc.step) begin
         if (acc_sum >= {div_k, 1'b0}) begin
            acc_ff   <= acc_sum - {div_k, 1'b0};
            pulse_ff <= ~pulse_ff;
         end else begin
            acc_ff <= acc_sum;
         end
      end
   end

   assign prdata    = prdata_ff;
   assign pready    = pready_ff;
   assign pslverr   = pslverr_ff;
   assign pulse_out = pulse_ff;
   assign stop_decel = decel_ff;
   assign stop_coast = coast_ff;
   assign irq       = irq_ff;
   assign overspeed_fault       = fault_ff[0];
   assign speed_deviation_fault = fault_ff[1];
   assign encoder_open_fault    = fault_ff[2];
   // =====================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_answer;
      pready ##1 !pready;
   endsequence
   AST_APB_ANSWER: assert property (acc_req |=> s_answer)
      else $error("APB answer not one pulse after one wait");
   AST_OS_SET: assert property (
      upd_ff && cond[0] && tmr_ff[0] >= lim[0] |=> overspeed_fault)
      else $error("overspeed not flagged after delay");
   AST_OS_CAUSE: assert property (
      $rose(overspeed_fault) |-> $past(upd_ff) && $past(cond[0]))
      else $error("overspeed flagged without cause");
   AST_DEV_SET: assert property (
      upd_ff && cond[1] && tmr_ff[1] >= lim[1] |=> speed_deviation_fault)
      else $error("deviation not flagged after delay");
   AST_PGO_SET: assert property (
      upd_ff && cond[2] && tmr_ff[2] >= lim[2] |=> encoder_open_fault)
      else $error("open circuit not flagged after time");
   AST_TMR_CLEAR: assert property (
      upd_ff && !cond[1] |=> tmr_ff[1] == 7'h0)
      else $error("timer not cleared when condition absent");
   AST_FAULT_HOLD: assert property (
      encoder_open_fault && !frst |=> encoder_open_fault)
      else $error("fault dropped without fault reset");
   AST_COAST: assert property (
      overspeed_fault && os_act_ff == ACT_COAST |=> stop_coast && !stop_decel)
      else $error("coast action not taken");
   AST_OS_RANGE: assert property (
      wr_take && paddr == ADDR_OS |=> os_lvl_ff <= OS_LVL_MAX)
      else $error("overspeed level out of range");
   AST_SPEED_ZERO: assert property (
      dv_ff == DV_DONE && den_ff == 26'h0 |=> speed_ff == 16'h0)
      else $error("speed not zero for zero resolution");
   AST_PULSE: assert property (
      enc.step && acc_sum >= {div_k, 1'b0} |=> pulse_out != $past(pulse_out))
      else $error("divided pulse did not toggle");
endmodule

// ==== eds_pkg.sv ====
// Purpose: Shared constants for the encoder feedback supervisor.
// Assumes: 200 MHz clock; registers reached over APB.
// Notes:   Offsets are byte addresses of aligned 32-bit words.
package eds_pkg;
   // =====================================================
   // Register offsets
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_OS     = 8'h04;
   localparam logic [7:0] ADDR_DEV    = 8'h08;
   localparam logic [7:0] ADDR_PGO    = 8'h0C;
   localparam logic [7:0] ADDR_PPR    = 8'h10;
   localparam logic [7:0] ADDR_DIV    = 8'h14;
   localparam logic [7:0] ADDR_GEAR   = 8'h18;
   localparam logic [7:0] ADDR_CMD    = 8'h1C;
   localparam logic [7:0] ADDR_MAX    = 8'h20;
   localparam logic [7:0] ADDR_SPEED  = 8'h24;
   localparam logic [7:0] ADDR_STATUS = 8'h28;
   localparam logic [7:0] ADDR_MASK   = 8'h2C;
   // =====================================================
   // Field positions
   localparam int FRST_BIT = 8;
   // =====================================================
   // Stop actions, value 0, 1 and 2 in that order
   typedef enum logic [1:0] {ACT_DECEL, ACT_COAST, ACT_RUN} eds_act_type;
   // =====================================================
   // Setting limits
   localparam logic [6:0]  OS_LVL_MAX   = 7'h78;
   localparam logic [4:0]  OS_TIME_MAX  = 5'h14;
   localparam logic [5:0]  DEV_LVL_MAX  = 6'h32;
   localparam logic [6:0]  DEV_TIME_MAX = 7'h64;
   localparam logic [6:0]  PGO_TIME_MAX = 7'h64;
   localparam logic [15:0] PPR_MAX      = 16'hEA60;
   localparam logic [9:0]  GEAR_MAX     = 10'h3E8;
   localparam logic [7:0]  DIV_HUND     = 8'h64;
   localparam logic [5:0]  DIV_K_MAX    = 6'h20;
   localparam logic [7:0]  PCT_FULL     = 8'h64;
   // =====================================================
   // Reset values
   localparam logic [6:0]  CTRL_RST     = 7'h11;
   localparam logic [6:0]  OS_LVL_RST   = 7'h73;
   localparam logic [4:0]  OS_TIME_RST  = 5'h0A;
   localparam logic [5:0]  DEV_LVL_RST  = 6'h0A;
   localparam logic [6:0]  DEV_TIME_RST = 7'h05;
   localparam logic [6:0]  PGO_TIME_RST = 7'h0A;
   localparam logic [15:0] PPR_RST      = 16'h0400;
   localparam logic [7:0]  DIV_RST      = 8'h01;
   localparam logic [9:0]  GEAR_RST     = 10'h001;
   localparam logic [15:0] MAX_RST      = 16'h0708;
   // =====================================================
   // Timing and speed scaling
   localparam int CLK_NS        = 5;
   localparam int TENTH_MS      = 100;
   localparam int TENTH_CYC_DEF = TENTH_MS * 1000000 / CLK_NS;
   localparam int SEC_PER_MIN   = 60;
   localparam int WIN_PER_SEC   = 10;
   localparam int EDGE_PER_PLS  = 4;
   localparam logic [7:0] RPM_MUL =
      8'(SEC_PER_MIN * WIN_PER_SEC / EDGE_PER_PLS);
   localparam logic [5:0] DIV_STEPS = 6'h26;
   localparam logic [6:0] TMR_SAT   = 7'h7F;
endpackage

// ==== eds_enc_if.sv ====
`timescale 1ns/100ps
// Purpose: Carries decoded encoder steps into the supervisor core.
// Assumes: One clock domain.
// Notes:   step is a one-cycle pulse; fwd is valid with it.
interface eds_enc_if;
   logic polarity; // Direction polarity, 1 reverses the sense.
   logic step;     // One valid quadrature edge seen.
   logic fwd;      // Edge was forward rotation.
   modport dec  (input polarity, output step, output fwd);
   modport core (output polarity, input step, input fwd);
endinterface

// ==== eds_quad.sv ====
`timescale 1ns/100ps
// Purpose: Synchronise and decode the shaft encoder phases.
// Assumes: Phases change far slower than the clock.
// Notes:   Double changes between samples are dropped as invalid.
module eds_quad (
   input  wire logic clk,   // System clock.
   input  wire logic reset, // Synchronous reset, active high.
   input  wire logic enc_a, // Encoder phase A.
   input  wire logic enc_b, // Encoder phase B.
   eds_enc_if.dec    enc    // Decoded steps out.
);
   import eds_pkg::*;
   logic [1:0] a_sync_ff;
   logic [1:0] b_sync_ff;
   logic       a_old_ff;
   logic       b_old_ff;
   logic       step_ff;
   logic       fwd_ff;
   // =====================================================
   // Synchronisers; stage 0 feeds only stage 1.
   always_ff @(posedge clk) begin
      if (reset) begin
         a_sync_ff <= 2'h0;
         b_sync_ff <= 2'h0;
      end else begin
         a_sync_ff <= {a_sync_ff[0], enc_a};
         b_sync_ff <= {b_sync_ff[0], enc_b};
      end
   end
   // =====================================================
   // decode signed steps
   always_ff @(posedge clk) begin
      if (reset) begin
         a_old_ff <= 1'b0;
         b_old_ff <= 1'b0;
         step_ff  <= 1'b0;
         fwd_ff   <= 1'b0;
      end else begin
         a_old_ff <= a_sync_ff[1];
         b_old_ff <= b_sync_ff[1];
         step_ff  <= (a_sync_ff[1] ^ a_old_ff) ^ (b_sync_ff[1] ^ b_old_ff);
         fwd_ff   <= ~(a_old_ff ^ b_sync_ff[1]) ^ enc.polarity;
      end
   end
   assign enc.step = step_ff;
   assign enc.fwd  = fwd_ff;
   AST_STEP_SINGLE: assert property (@(posedge clk) disable iff (reset)
      step_ff |-> $past(a_sync_ff[1] ^ a_old_ff)
                  != $past(b_sync_ff[1] ^ b_old_ff))
      else $error("step taken on an invalid phase change");
endmodule

// ==== eds_enc_model.sv ====
// Purpose: Shaft encoder model driving the two quadrature phases.
// Assumes: One phase edge every five clocks while turning.
// Notes:   Phases hold their level when the shaft stops.
`timescale 1ns/100ps
module eds_enc_model (
   input  wire logic clk,   // System clock.
   input  wire logic run,   // Shaft turning.
   input  wire logic rev,   // Turning backwards, B leads A.
   output logic      enc_a, // Phase A.
   output logic      enc_b  // Phase B.
);
   logic [2:0] cnt_ff = 3'h0; // Edge spacing counter.
   logic [1:0] pos_ff = 2'h0; // Binary position of the shaft; the phases are its Gray code.
   // =========================================
   // Stepping
   // Five cycles per edge keeps edges legally apart.
   always_ff @(posedge clk) begin
      cnt_ff <= (cnt_ff == 3'h4 || !run) ? 3'h0 : cnt_ff + 3'h1;
      if (run && cnt_ff == 3'h4) begin
         pos_ff <= rev ? pos_ff - 2'h1 : pos_ff + 2'h1;
      end
   end
   assign enc_a = ^pos_ff; // Leads B when counting up.
   assign enc_b = pos_ff[1];
endmodule

// ==== encoder_feedback_supervisor_tb.sv ====
// Purpose: Self-checking bench for the encoder supervisor.
// Assumes: Speed window of 100 cycles, 20 edges per window.
// Notes:   Waits are fixed by window counts; a timeout cuts hangs.
`timescale 1ns/100ps
module encoder_feedback_supervisor_tb;
   import eds_pkg::*;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic        run = 1'b0;
   logic        rev = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, err, a, b, pls, dec, cst, irq, fo, fd, fp;
   int          mismatches = 0;
   int          n_compared = 0;
   int          cyc = 0;
   eds_top #(.TENTH_CYC(100)) dut (.clk(clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .enc_a(a),
      .enc_b(b), .pulse_out(pls), .stop_decel(dec), .stop_coast(cst),
      .irq(irq), .overspeed_fault(fo), .speed_deviation_fault(fd),
      .encoder_open_fault(fp));
   eds_enc_model enc (.clk(clk), .run(run), .rev(rev), .enc_a(a), .enc_b(b));
   // =========================================
   // Clock and timeout
   // The clock toggles every half period of 2.5 ns.
   initial begin
      forever #2.5 clk = ~clk;
   end
   // A hang counts as a mismatch and closes the run.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 12000) begin
         mismatches++;
         end_sim();
      end
   end
   // =========================================
   // Shared tasks
   // APB transfer held until pready is seen at a rising edge.
   task automatic apb(input logic wr, input logic [7:0] ad,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Counts pulse_out toggles over 200 cycles, which is 40 encoder edges.
   task automatic pls_cnt(input int exp);
      int   n = 0;
      logic last;
      last = pls;
      repeat (200) begin
         @(posedge clk);
         if (pls !== last)
            n++;
         last = pls;
      end
      chk(32'(n), 32'(exp));
   endtask
   task automatic rdc(input logic [7:0] ad, input logic [31:0] exp);
      apb(1'b0, ad, 32'h0);
      chk(rd, exp);
   endtask
   task automatic refused(input logic [7:0] ad, input logic [31:0] d);
      apb(1'b1, ad, d);
      chk(32'(err), 32'h1);
   endtask
   task automatic end_sim;
      $display("mismatches=%0d compared=%0d", mismatches, n_compared);
      if (mismatches == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // =========================================
   // Scenarios
   // Reset values, refused settings and an unmapped read.
   task automatic t_regs;
      rdc(ADDR_CTRL, 32'h11);
      rdc(8'h04, 32'hA73);
      rdc(ADDR_PPR, 32'h400);
      refused(ADDR_CTRL, 32'h13);
      refused(8'h04, 32'h79);
      refused(ADDR_DIV, 32'h21);
      refused(ADDR_GEAR, 32'h10000);
      rdc(ADDR_CTRL, 32'h11);
      rdc(8'h30, 32'h0);
      chk(32'(err), 32'h1);
   endtask
   // Speed through resolution, gear ratio and direction sense.
   task automatic t_speed;
      apb(1'b1, ADDR_PPR, 32'h4);
      run <= 1'b1;
      repeat (500) @(posedge clk);
      rdc(ADDR_SPEED, 32'h2EE);
      pls_cnt(20);
      apb(1'b1, ADDR_DIV, 32'h4);
      pls_cnt(5);
      apb(1'b1, ADDR_GEAR, 32'h40002);
      repeat (300) @(posedge clk);
      rdc(ADDR_SPEED, 32'h5DC);
      rev <= 1'b1;
      repeat (300) @(posedge clk);
      rdc(ADDR_SPEED, 32'h105DC);
      apb(1'b1, ADDR_CTRL, 32'h51);
      repeat (300) @(posedge clk);
      rdc(ADDR_SPEED, 32'h5DC);
   endtask
   // Overspeed delay, action, interrupt, hold and reset.
   task automatic t_os;
      apb(1'b1, ADDR_MAX, 32'h3E8);
      apb(1'b1, ADDR_MASK, 32'h1);
      apb(1'b1, 8'h04, 32'h332);
      repeat (250) @(posedge clk);
      chk(32'(fo), 32'h0);
      repeat (300) @(posedge clk);
      chk(32'({fo, irq, cst, dec}), 32'hE);
      apb(1'b1, ADDR_CTRL, 32'h52);
      apb(1'b1, ADDR_MASK, 32'h0);
      repeat (2) @(posedge clk);
      chk(32'({fo, irq, cst, dec}), 32'h8);
      run <= 1'b0;
      apb(1'b1, ADDR_STATUS, 32'h1);
      apb(1'b1, ADDR_MASK, 32'h1);
      repeat (300) @(posedge clk);
      chk(32'({fo, irq}), 32'h2);
      apb(1'b1, ADDR_CTRL, 32'h151);
      repeat (2) @(posedge clk);
      chk(32'({fo, cst}), 32'h0);
   endtask
   // Open encoder and deviation with the shaft stopped.
   task automatic t_open;
      apb(1'b1, ADDR_CMD, 32'hC8);
      repeat (1300) @(posedge clk);
      chk(32'({fp, fd, cst, dec}), 32'hE);
      apb(1'b1, ADDR_CTRL, 32'h41);
      repeat (2) @(posedge clk);
      chk(32'({cst, dec}), 32'h1);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      t_regs();
      t_speed();
      t_os();
      t_open();
      end_sim();
   end
endmodule
